// [hdl/lcdce_cascade.sv]
/*
 * Cascade enable chain and direction-dependent data pin routing of an
 * 80-output LCD common/segment driver.
 * Assumes shift clock, line latch and the pins arrive asynchronously and are
 * sampled on sys_clk; configuration pins are static during a line.
 */
`timescale 1ns/1ps

// What this block does
// - Cascaded segment drivers enabled one at a time
// - Direction low: right enable in, left out
// - Direction high: left enable in, right out
// - No enable chain in common use
// - Single common: left in, right out, swapped
// - Dual common: middle plus end pin inputs
module lcdce_cascade #(
    parameter int unsigned SHARE_LEN = lcdce_pkg::SHARE_CLOCKS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Configuration pins
    input wire logic common_select,
    input wire logic dual_mode,
    input wire logic shift_direction_select,
    // Timing controller strobes
    input wire logic shift_clock,
    input wire logic line_latch,
    // Enable pins
    input wire logic left_enable_pin_i,
    output logic left_enable_pin_o,
    output logic left_enable_pin_oe,
    input wire logic right_enable_pin_i,
    output logic right_enable_pin_o,
    output logic right_enable_pin_oe,
    // Common shift data pins
    input wire logic left_data_pin_i,
    output logic left_data_pin_o,
    output logic left_data_pin_oe,
    input wire logic right_data_pin_i,
    output logic right_data_pin_o,
    output logic right_data_pin_oe,
    input wire logic middle_data_pin_i,
    // Core side
    output logic driver_active,
    output logic data_take,
    output logic [1:0] shift_input,
    input wire logic shift_output
);

////////////////////////////////////////////////////////////////////////////////
// Three-stage pin synchronisers; change counts once stages 2 and 3 agree

    localparam int NSYNC = 7;
    logic [NSYNC-1:0] pins_raw;
    logic [NSYNC-1:0] s1_q, s2_q, s3_q, flt_q, flt_d;
    assign pins_raw = {shift_clock, line_latch, left_enable_pin_i,
        right_enable_pin_i, left_data_pin_i, right_data_pin_i,
        middle_data_pin_i};

    always_comb begin
        flt_d = flt_q;
        for (int i = 0; i < NSYNC; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                flt_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Idle pin levels, or the enable chain sees a false token
            s1_q <= lcdce_pkg::PIN_SYNC_RESET;
            s2_q <= lcdce_pkg::PIN_SYNC_RESET;
            s3_q <= lcdce_pkg::PIN_SYNC_RESET;
            flt_q <= lcdce_pkg::PIN_SYNC_RESET;
        end else begin
            s1_q <= pins_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            flt_q <= flt_d;
        end
    end

    logic sck_s, lat_s, len_s, ren_s, ldat_s, rdat_s, mdat_s;
    assign {sck_s, lat_s, len_s, ren_s, ldat_s, rdat_s, mdat_s} = flt_q;

    logic sck_prev_q, lat_prev_q;
    logic sck_rise, lat_rise;
    assign sck_rise = sck_s & ~sck_prev_q;
    assign lat_rise = lat_s & ~lat_prev_q;

////////////////////////////////////////////////////////////////////////////////
// Segment enable chain

    localparam int unsigned SHARE_CNT_W = lcdce_pkg::SHARE_CNT_W;
    lcdce_pkg::lcdce_seg_state_t state_q, state_d;
    logic [lcdce_pkg::SHARE_CNT_W-1:0] cnt_q, cnt_d;
    logic enable_in;
    logic seg_mode;
    logic en_out_d, en_out_q;
    logic take_d, take_q;
    logic active_d, active_q;

    assign seg_mode = ~common_select;
    // Enable input pin follows the direction select
    assign enable_in = shift_direction_select ? len_s : ren_s;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        take_d = 1'b0;
        unique case (state_q)
            lcdce_pkg::LCDCE_SEG_IDLE: begin
                if (seg_mode && !enable_in) begin
                    state_d = lcdce_pkg::LCDCE_SEG_ACTIVE;
                    cnt_d = '0;
                end
            end
            lcdce_pkg::LCDCE_SEG_ACTIVE: begin
                if (sck_rise) begin
                    take_d = 1'b1;
                    if (cnt_q == SHARE_CNT_W'(SHARE_LEN - 1)) begin
                        state_d = lcdce_pkg::LCDCE_SEG_DONE;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
                if (enable_in || !seg_mode) begin
                    state_d = lcdce_pkg::LCDCE_SEG_IDLE;
                end
            end
            lcdce_pkg::LCDCE_SEG_DONE: begin
                // Hold the chain until the line is latched
                if (lat_rise || !seg_mode) begin
                    state_d = lcdce_pkg::LCDCE_SEG_IDLE;
                end
            end
        endcase
        if (lat_rise) begin
            state_d = lcdce_pkg::LCDCE_SEG_IDLE;
        end
        en_out_d = (state_d == lcdce_pkg::LCDCE_SEG_DONE) ? 1'b0 :
            lcdce_pkg::ENABLE_OUT_RESET;
        active_d = seg_mode ? (state_d == lcdce_pkg::LCDCE_SEG_ACTIVE)
            : 1'b1;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= lcdce_pkg::LCDCE_SEG_IDLE;
            cnt_q <= '0;
            en_out_q <= lcdce_pkg::ENABLE_OUT_RESET;
            take_q <= 1'b0;
            active_q <= 1'b0;
            sck_prev_q <= 1'b0;
            lat_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            en_out_q <= en_out_d;
            take_q <= take_d;
            active_q <= active_d;
            sck_prev_q <= sck_s;
            lat_prev_q <= lat_s;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Pin direction and data routing

    lcdce_pkg::lcdce_pin_drive_t len_d, ren_d, ldat_d, rdat_d;
    lcdce_pkg::lcdce_pin_drive_t len_q, ren_q, ldat_q, rdat_q;
    logic [1:0] sin_d, sin_q;

    always_comb begin
        len_d = '{o: 1'b0, oe: 1'b0};
        ren_d = '{o: 1'b0, oe: 1'b0};
        ldat_d = '{o: 1'b0, oe: 1'b0};
        rdat_d = '{o: 1'b0, oe: 1'b0};
        sin_d = 2'h0;
        if (seg_mode) begin
            // Enable output on the pin opposite the input
            if (shift_direction_select) begin
                ren_d = '{o: en_out_d, oe: 1'b1};
            end else begin
                len_d = '{o: en_out_d, oe: 1'b1};
            end
        end else if (shift_direction_select) begin
            ldat_d = '{o: shift_output, oe: 1'b1};
            sin_d[0] = rdat_s;
            sin_d[1] = dual_mode ? mdat_s : 1'b0;
        end else begin
            rdat_d = '{o: shift_output, oe: 1'b1};
            sin_d[0] = ldat_s;
            sin_d[1] = dual_mode ? mdat_s : 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            len_q <= '{o: 1'b0, oe: 1'b0};
            ren_q <= '{o: 1'b0, oe: 1'b0};
            ldat_q <= '{o: 1'b0, oe: 1'b0};
            rdat_q <= '{o: 1'b0, oe: 1'b0};
            sin_q <= 2'h0;
        end else begin
            len_q <= len_d;
            ren_q <= ren_d;
            ldat_q <= ldat_d;
            rdat_q <= rdat_d;
            sin_q <= sin_d;
        end
    end

    assign left_enable_pin_o = len_q.o;
    assign left_enable_pin_oe = len_q.oe;
    assign right_enable_pin_o = ren_q.o;
    assign right_enable_pin_oe = ren_q.oe;
    assign left_data_pin_o = ldat_q.o;
    assign left_data_pin_oe = ldat_q.oe;
    assign right_data_pin_o = rdat_q.o;
    assign right_data_pin_oe = rdat_q.oe;
    assign shift_input = sin_q;
    assign driver_active = active_q;
    assign data_take = take_q;

////////////////////////////////////////////////////////////////////////////////
// Assertions

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_take_when_on: assert property (
        data_take |-> $past(state_q == lcdce_pkg::LCDCE_SEG_ACTIVE))
        else $error("data taken while not enabled");
    a_dir_low_pins: assert property (
        (seg_mode && !shift_direction_select) [*2] |->
            left_enable_pin_oe && !right_enable_pin_oe)
        else $error("direction low enable pins wrong");
    a_dir_high_pins: assert property (
        (seg_mode && shift_direction_select) [*2] |->
            right_enable_pin_oe && !left_enable_pin_oe)
        else $error("direction high enable pins wrong");
    a_common_no_chain: assert property (
        !seg_mode [*2] |-> !left_enable_pin_oe && !right_enable_pin_oe)
        else $error("enable chain driven in common use");
    a_single_route: assert property (
        (!seg_mode && !shift_direction_select) [*2] |->
            right_data_pin_oe && !left_data_pin_oe)
        else $error("single common routing wrong");
    a_dual_middle: assert property (
        !seg_mode && dual_mode |=> shift_input[1] == $past(mdat_s))
        else $error("dual middle input not routed");
    a_done_low_out: assert property (
        state_q == lcdce_pkg::LCDCE_SEG_DONE && seg_mode && !lat_rise
            && !shift_direction_select |-> ##1 !left_enable_pin_o)
        else $error("enable output not low after share");
    a_idle_out_high: assert property (
        state_q == lcdce_pkg::LCDCE_SEG_IDLE |-> en_out_q)
        else $error("enable output low while idle");

    c_share_done: cover property (
        state_q == lcdce_pkg::LCDCE_SEG_ACTIVE ##1
            state_q == lcdce_pkg::LCDCE_SEG_DONE);
    c_dir_high: cover property (seg_mode && shift_direction_select
        && driver_active);
    c_dual: cover property (!seg_mode && dual_mode);

endmodule // lcdce_cascade

// [hdl/lcdce_pkg.sv]
/*
 * Package of the LCD driver cascade enable block: segment chain states, data share
 * length and the packed pin bundles.
 * Assumes a single 200 MHz system clock and synchronous active-high reset.
 */
package lcdce_pkg;

    // Data share: 20 shift clocks of 4-bit data fill 80 segment outputs
    localparam int unsigned SHARE_CLOCKS = 20;
    localparam int unsigned SHARE_CNT_W = 5;
    // Reset value of the enable output: high means next driver disabled
    localparam logic ENABLE_OUT_RESET = 1'b1;
    // Pin filter reset, bit 6 first: shift clock, latch, left enable,
    // right enable, left data, right data, middle data. Enable pins idle
    // high through their pull-ups, so reset must not look like a token.
    localparam logic [6:0] PIN_SYNC_RESET = 7'h18;

    typedef enum logic [1:0] {
        LCDCE_SEG_IDLE,
        LCDCE_SEG_ACTIVE,
        LCDCE_SEG_DONE
    } lcdce_seg_state_t;

    // Driven side of a two-way pin: value and output enable
    typedef struct packed {
        logic o;
        logic oe;
    } lcdce_pin_drive_t;

endpackage

// [verif/lcdce_ctrl_model.sv]
/*
 * Model of the timing controller and the upstream cascaded driver.
 * Assumes the bench resolves the shared pins and waits out reset.
 */
`timescale 1ns/1ps
module lcdce_ctrl_model (
    // Clock
    input wire logic sys_clk,
    // Strobes
    output logic shift_clock,
    output logic line_latch,
    // Upstream enable token and common shift data
    output logic up_enable,
    output logic end_data,
    output logic mid_data
);
    initial begin
        shift_clock = 1'b0;
        line_latch = 1'b0;
        up_enable = 1'b1;
        end_data = 1'b0;
        mid_data = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // Phases of 4 cycles stay clear of the 3-cycle pin filter
    task automatic shift(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            shift_clock <= 1'b1;
            repeat (4) @(posedge sys_clk);
            shift_clock <= 1'b0;
            repeat (3) @(posedge sys_clk);
        end
    endtask
    task automatic latch();
        @(posedge sys_clk);
        line_latch <= 1'b1;
        repeat (4) @(posedge sys_clk);
        line_latch <= 1'b0;
    endtask
    // A released token reads high through the pin pull-up
    task automatic token(input logic low);
        @(posedge sys_clk);
        up_enable <= ~low;
    endtask
    task automatic data(input logic e, input logic m);
        @(posedge sys_clk);
        end_data <= e;
        mid_data <= m;
    endtask
endmodule // lcdce_ctrl_model

// [verif/lcdce_cascade_tb_top.sv]
/*
 * Self-checking bench of the cascade enable and pin routing block.
 * Assumes the controller model drives strobes and resolves no pins itself.
 */
`timescale 1ns/1ps
module lcdce_cascade_tb_top;
    localparam int LEN = 20;
    logic sys_clk, rst, common_select, dual_mode, shift_direction_select;
    logic shift_clock, line_latch, shift_output, driver_active, data_take;
    logic left_enable_pin_o, left_enable_pin_oe, right_enable_pin_o;
    logic right_enable_pin_oe, left_data_pin_o, left_data_pin_oe;
    logic right_data_pin_o, right_data_pin_oe, up_enable, end_data;
    logic middle_data_pin_i;
    logic [1:0] shift_input;
    int fails, compares, takes;
    wire dir = shift_direction_select;
    // Pins resolved from both parties; undriven enable pins pull up
    wire left_enable_pin_i = left_enable_pin_oe ? left_enable_pin_o
                             : (dir ? up_enable : 1'b1);
    wire right_enable_pin_i = right_enable_pin_oe ? right_enable_pin_o
                              : (dir ? 1'b1 : up_enable);
    wire left_data_pin_i = left_data_pin_oe ? left_data_pin_o : end_data;
    wire right_data_pin_i = right_data_pin_oe ? right_data_pin_o : end_data;
    wire [1:0] en_out = dir ? {right_enable_pin_oe, right_enable_pin_o}
                        : {left_enable_pin_oe, left_enable_pin_o};
    wire en_in_oe = dir ? left_enable_pin_oe : right_enable_pin_oe;
    wire [1:0] d_out = dir ? {left_data_pin_oe, left_data_pin_o}
                       : {right_data_pin_oe, right_data_pin_o};
    wire d_in_oe = dir ? right_data_pin_oe : left_data_pin_oe;

    lcdce_ctrl_model ctrl (.sys_clk, .shift_clock, .line_latch, .up_enable,
        .end_data, .mid_data(middle_data_pin_i));
    lcdce_cascade #(.SHARE_LEN(LEN)) dut (.sys_clk, .rst, .common_select,
        .dual_mode, .shift_direction_select, .shift_clock, .line_latch,
        .left_enable_pin_i, .left_enable_pin_o, .left_enable_pin_oe,
        .right_enable_pin_i, .right_enable_pin_o, .right_enable_pin_oe,
        .left_data_pin_i, .left_data_pin_o, .left_data_pin_oe,
        .right_data_pin_i, .right_data_pin_o, .right_data_pin_oe,
        .middle_data_pin_i, .driver_active, .data_take, .shift_input,
        .shift_output);
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Away from the launching edge, so each one-cycle pulse counts once
    always @(negedge sys_clk) if (data_take === 1'b1) takes++;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (10) @(posedge sys_clk);
    endtask
    task automatic summarize();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Segment line: refused while disabled, one share, token passed on
    task automatic seg_line(input logic d);
        @(posedge sys_clk);
        common_select <= 1'b0;
        shift_direction_select <= d;
        settle();
        takes = 0;
        ctrl.shift(3);
        settle();
        chk(8'(takes), 8'h00);
        chk(8'(driver_active), 8'h00);
        chk(8'(en_out), 8'h03);
        ctrl.token(1'b1);
        settle();
        chk(8'(driver_active), 8'h01);
        chk(8'(en_in_oe), 8'h00);
        ctrl.shift(LEN);
        settle();
        chk(8'(takes), 8'(LEN));
        chk(8'(en_out), 8'h02);
        chk(8'(driver_active), 8'h00);
        ctrl.token(1'b0);
        ctrl.latch();
        settle();
        chk(8'(en_out), 8'h03);
    endtask
    // Common routing for one direction and mode, both data levels
    task automatic com_route(input logic d, input logic du);
        @(posedge sys_clk);
        common_select <= 1'b1;
        shift_direction_select <= d;
        dual_mode <= du;
        // A low token must not wake the enable chain in common use
        ctrl.token(1'b1);
        for (int v = 0; v < 2; v++) begin
            ctrl.data(v[0], ~v[0]);
            shift_output <= v[0];
            settle();
            chk(8'(shift_input), 8'({du & ~v[0], v[0]}));
            chk(8'(d_out), 8'({1'b1, v[0]}));
            chk(8'(d_in_oe), 8'h00);
            chk(8'(driver_active), 8'h01);
            chk(8'({left_enable_pin_oe, right_enable_pin_oe}), 8'h00);
        end
        ctrl.token(1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        common_select = 1'b0;
        dual_mode = 1'b0;
        shift_direction_select = 1'b0;
        shift_output = 1'b0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        seg_line(1'b0);
        seg_line(1'b1);
        for (int i = 0; i < 4; i++) com_route(i[0], i[1]);
        summarize();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        summarize();
    end
endmodule // lcdce_cascade_tb_top
